// ---- pfc_pkg.sv ----
// pfc_pkg: register map, reset values and state layout of the pad control block
//==============================================================================
// Summary of operation
// - port D pins 2-7 have own direction
// - region selects drive pins active low
// - drive bit decides idle-bus high impedance
// - port D 2-5 reset as pulled-up inputs
// - port D pull-up off when bit cleared
// - port E bits 0,1 gate serial0 pull-ups
// - serial pins usable as directed port pins
// - transmit pins undriven, pulled up in reset
// - receive pins pulled-up inputs, then serial
// - test-port bit switches test pull-ups off
// - test clock pin always pulled down
// - region-select function only after enable bit set; serial pins reset to peripheral
package pfc_pkg;
    //==========================================================================
    // register byte offsets
    localparam logic [7:0] ADR_PD_PULL = 8'h00;
    localparam logic [7:0] ADR_PD_DIR = 8'h04;
    localparam logic [7:0] ADR_PD_DOUT = 8'h08;
    localparam logic [7:0] ADR_PD_PER = 8'h0C;
    localparam logic [7:0] ADR_PE_PULL = 8'h10;
    localparam logic [7:0] ADR_PE_DIR = 8'h14;
    localparam logic [7:0] ADR_PE_DOUT = 8'h18;
    localparam logic [7:0] ADR_PE_PER = 8'h1C;
    localparam logic [7:0] ADR_BUS_CTRL = 8'h20;
    localparam logic [7:0] ADR_PUD_CTRL = 8'h24;
    localparam logic [7:0] ADR_PIN_LEVEL = 8'h28;
    //==========================================================================
    // field positions
    localparam int PD_LSB = 2;
    localparam int PD_MSB = 7;
    localparam int PE_LSB = 0;
    localparam int PE_MSB = 1;
    localparam int BUS_DRV_BIT = 0;
    localparam int PUD_TEST_BIT = 0;
    localparam int NPAD = 8;
    //==========================================================================
    // reset values, one bit per pin in field order
    localparam logic [5:0] PD_PULL_RST = 6'h3F;
    localparam logic [5:0] PD_DIR_RST = 6'h00;
    localparam logic [5:0] PD_DOUT_RST = 6'h00;
    localparam logic [5:0] PD_PER_RST = 6'h30;
    localparam logic [1:0] PE_PULL_RST = 2'h3;
    localparam logic [1:0] PE_DIR_RST = 2'h0;
    localparam logic [1:0] PE_DOUT_RST = 2'h0;
    localparam logic [1:0] PE_PER_RST = 2'h3;
    localparam logic DRV_RST = 1'h0;
    localparam logic PUD_RST = 1'h0;
    //==========================================================================
    // state of the top module
    typedef struct packed {
        logic [5:0] d_pull;
        logic [5:0] d_dir;
        logic [5:0] d_dout;
        logic [5:0] d_per;
        logic [1:0] e_pull;
        logic [1:0] e_dir;
        logic [1:0] e_dout;
        logic [1:0] e_per;
        logic drv;
        logic test_pud;
        logic out_ok;
        logic ack;
        logic [31:0] rdata;
    } pfc_state_t;

    localparam pfc_state_t STATE_RST = '{
        d_pull: PD_PULL_RST,
        d_dir: PD_DIR_RST,
        d_dout: PD_DOUT_RST,
        d_per: PD_PER_RST,
        e_pull: PE_PULL_RST,
        e_dir: PE_DIR_RST,
        e_dout: PE_DOUT_RST,
        e_per: PE_PER_RST,
        drv: DRV_RST,
        test_pud: PUD_RST,
        out_ok: 1'h0,
        ack: 1'h0,
        rdata: 32'h0000_0000
    };
endpackage : pfc_pkg

// ---- pfc_pad.sv ----
// pfc_pad: function and drive selection of one shared pad
`timescale 1ns/10ps
module pfc_pad (
    input wire logic per_sel,
    input wire logic gpio_dir,
    input wire logic gpio_out,
    input wire logic per_oe,
    input wire logic per_out,
    input wire logic out_ok,
    input wire logic pull_en,
    input wire logic pad_i,
    output logic pad_o,
    output logic pad_oe,
    output logic pad_pu,
    output logic in_level
);
    //==========================================================================
    // mux
    // out_ok stays low through reset so no driver turns on before release
    assign pad_oe = out_ok & (per_sel ? per_oe : gpio_dir);
    assign pad_o = per_sel ? per_out : gpio_out;
    assign pad_pu = pull_en;
    assign in_level = pad_i;
endmodule : pfc_pad

// ---- pfc_top.sv ----
// pfc_top: pad function, direction and pull control behind a wishbone slave
//
// Our own choices: the address map and the Wishbone register port.
`timescale 1ns/10ps
module pfc_top (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [3:0] EMI_REGION_SELECT_N,
    input wire logic EMI_BUS_ACTIVE,
    input wire logic [1:0] SERIAL_TXD,
    output logic [1:0] SERIAL_RXD,
    input wire logic [7:2] PD_I,
    output logic [7:2] PD_O,
    output logic [7:2] PD_OE,
    output logic [7:2] PD_PU,
    input wire logic [1:0] PE_I,
    output logic [1:0] PE_O,
    output logic [1:0] PE_OE,
    output logic [1:0] PE_PU,
    output logic TMS_PU,
    output logic TDI_PU,
    output logic TCK_PD
);
    pfc_pkg::pfc_state_t s;
    pfc_pkg::pfc_state_t next_s;
    logic req;
    logic [7:0] adr_word;
    logic [7:0] in_level;
    logic [7:0] pad_o;
    logic [7:0] pad_oe;
    logic [7:0] pad_pu;
    logic [7:0] per_sel;
    logic [7:0] per_out;
    logic [7:0] per_oe;
    logic cs_oe;

    assign req = WB_CYC_I & WB_STB_I;
    assign adr_word = {WB_ADR_I[7:2], 2'h0};

    //==========================================================================
    // read mux
    function automatic logic [31:0] rd_mux(
        input logic [7:0] a,
        input pfc_pkg::pfc_state_t st,
        input logic [7:0] lvl
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            pfc_pkg::ADR_PD_PULL: begin
                w[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB] = st.d_pull;
            end
            pfc_pkg::ADR_PD_DIR: begin
                w[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB] = st.d_dir;
            end
            pfc_pkg::ADR_PD_DOUT: begin
                w[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB] = st.d_dout;
            end
            pfc_pkg::ADR_PD_PER: begin
                w[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB] = st.d_per;
            end
            pfc_pkg::ADR_PE_PULL: begin
                w[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB] = st.e_pull;
            end
            pfc_pkg::ADR_PE_DIR: begin
                w[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB] = st.e_dir;
            end
            pfc_pkg::ADR_PE_DOUT: begin
                w[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB] = st.e_dout;
            end
            pfc_pkg::ADR_PE_PER: begin
                w[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB] = st.e_per;
            end
            pfc_pkg::ADR_BUS_CTRL: begin
                w[pfc_pkg::BUS_DRV_BIT] = st.drv;
            end
            pfc_pkg::ADR_PUD_CTRL: begin
                w[pfc_pkg::PUD_TEST_BIT] = st.test_pud;
            end
            pfc_pkg::ADR_PIN_LEVEL: begin
                // pad levels: port D in bits 7:2, port E in bits 1:0
                w[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB] = lvl[5:0];
                w[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB] = lvl[7:6];
            end
            default: begin
                w = 32'h0000_0000;
            end
        endcase
        return w;
    endfunction : rd_mux

    //==========================================================================
    // next state
    always_comb begin
        next_s = s;
        next_s.out_ok = 1'b1;
        next_s.ack = req & ~s.ack;
        if (req & ~s.ack) begin
            next_s.rdata = rd_mux(adr_word, s, in_level);
        end
        // writes land on the edge where the master sees ack, never earlier
        if (req & s.ack & WB_WE_I & WB_SEL_I[0]) begin
            case (adr_word)
                pfc_pkg::ADR_PD_PULL: begin
                    next_s.d_pull = WB_DAT_I[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB];
                end
                pfc_pkg::ADR_PD_DIR: begin
                    next_s.d_dir = WB_DAT_I[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB];
                end
                pfc_pkg::ADR_PD_DOUT: begin
                    next_s.d_dout = WB_DAT_I[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB];
                end
                pfc_pkg::ADR_PD_PER: begin
                    next_s.d_per = WB_DAT_I[pfc_pkg::PD_MSB:pfc_pkg::PD_LSB];
                end
                pfc_pkg::ADR_PE_PULL: begin
                    next_s.e_pull = WB_DAT_I[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB];
                end
                pfc_pkg::ADR_PE_DIR: begin
                    next_s.e_dir = WB_DAT_I[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB];
                end
                pfc_pkg::ADR_PE_DOUT: begin
                    next_s.e_dout = WB_DAT_I[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB];
                end
                pfc_pkg::ADR_PE_PER: begin
                    next_s.e_per = WB_DAT_I[pfc_pkg::PE_MSB:pfc_pkg::PE_LSB];
                end
                pfc_pkg::ADR_BUS_CTRL: begin
                    next_s.drv = WB_DAT_I[pfc_pkg::BUS_DRV_BIT];
                end
                pfc_pkg::ADR_PUD_CTRL: begin
                    next_s.test_pud = WB_DAT_I[pfc_pkg::PUD_TEST_BIT];
                end
                default: begin
                    next_s.ack = 1'b0;
                end
            endcase
        end
    end

    //==========================================================================
    // state register
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s <= pfc_pkg::STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    //==========================================================================
    // pad wiring, pads 0-5 are port D 2-7, pads 6-7 are port E 0-1
    // region selects float on an idle bus unless the drive bit is set
    assign cs_oe = s.drv | EMI_BUS_ACTIVE;
    assign per_sel = {s.e_per, s.d_per};
    assign per_out = {1'b1, SERIAL_TXD[0], 1'b1, SERIAL_TXD[1], EMI_REGION_SELECT_N};
    assign per_oe = {1'b0, 1'b1, 1'b0, 1'b1, {4{cs_oe}}};

    genvar k;
    generate
        for (k = 0; k < pfc_pkg::NPAD; k++) begin : g_pad
            pfc_pad u_pad (
                .per_sel(per_sel[k]),
                .gpio_dir(k < 6 ? s.d_dir[k % 6] : s.e_dir[k % 2]),
                .gpio_out(k < 6 ? s.d_dout[k % 6] : s.e_dout[k % 2]),
                .per_oe(per_oe[k]),
                .per_out(per_out[k]),
                .out_ok(s.out_ok),
                .pull_en(k < 6 ? s.d_pull[k % 6] : s.e_pull[k % 2]),
                .pad_i(k < 6 ? PD_I[(k % 6) + 2] : PE_I[k % 2]),
                .pad_o(pad_o[k]),
                .pad_oe(pad_oe[k]),
                .pad_pu(pad_pu[k]),
                .in_level(in_level[k])
            );
        end
    endgenerate

    //==========================================================================
    // outputs
    assign PD_O = pad_o[5:0];
    assign PD_OE = pad_oe[5:0];
    assign PD_PU = pad_pu[5:0];
    assign PE_O = pad_o[7:6];
    assign PE_OE = pad_oe[7:6];
    assign PE_PU = pad_pu[7:6];
    // receive lines idle high while their pad is a port pin
    assign SERIAL_RXD[0] = s.e_per[1] ? in_level[7] : 1'b1;
    assign SERIAL_RXD[1] = s.d_per[5] ? in_level[5] : 1'b1;
    assign TMS_PU = ~s.test_pud;
    assign TDI_PU = ~s.test_pud;
    assign TCK_PD = 1'b1;
    assign WB_DAT_O = s.rdata;
    assign WB_ACK_O = s.ack;
endmodule : pfc_top

// ---- pfc_props.sv ----
// pfc_props: port-level checks of the pad control block
`timescale 1ns/10ps
module pfc_props (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic [3:0] EMI_REGION_SELECT_N,
    input wire logic EMI_BUS_ACTIVE,
    input wire logic [1:0] SERIAL_TXD,
    input wire logic [7:2] PD_O,
    input wire logic [7:2] PD_OE,
    input wire logic [7:2] PD_PU,
    input wire logic TMS_PU,
    input wire logic TCK_PD
);
    // ======
    // register mirrors, loaded at the ack edge like the design
    logic up;
    logic drv;
    logic [7:2] per;
    logic [7:2] dir;
    wire wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O && WB_SEL_I[0];
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            up <= 1'b0;
            drv <= pfc_pkg::DRV_RST;
            per <= pfc_pkg::PD_PER_RST;
            dir <= pfc_pkg::PD_DIR_RST;
        end else begin
            up <= 1'b1;
            if (wr && WB_ADR_I == pfc_pkg::ADR_BUS_CTRL) drv <= WB_DAT_I[0];
            if (wr && WB_ADR_I == pfc_pkg::ADR_PD_PER) per <= WB_DAT_I[7:2];
            if (wr && WB_ADR_I == pfc_pkg::ADR_PD_DIR) dir <= WB_DAT_I[7:2];
        end
    end
    sequence s_wr(a);
        wr && WB_ADR_I == a;
    endsequence
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // ======
    // assertions
    AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack too long");
    AST_ACK_NEXT: assert property ($rose(WB_STB_I) && WB_CYC_I |=> WB_ACK_O)
        else $error("ack late");
    AST_TCK_LOW: assert property (TCK_PD) else $error("no pull-down");
    AST_TEST_PULL:
        assert property (s_wr(pfc_pkg::ADR_PUD_CTRL) |=> TMS_PU == !$past(WB_DAT_I[0]))
        else $error("test pull wrong");
    AST_PD_PULL:
        assert property (s_wr(pfc_pkg::ADR_PD_PULL) |=> PD_PU == $past(WB_DAT_I[7:2]))
        else $error("port pull wrong");
    AST_GPIO_DIR: assert property (up |-> ((PD_OE ^ dir) & ~per) == 6'h00)
        else $error("direction wrong");
    AST_SEL_LEVEL:
        assert property (up |-> ((PD_O[5:2] ^ EMI_REGION_SELECT_N) & per[5:2]) == 4'h0)
        else $error("select level wrong");
    AST_SEL_DRIVE:
        assert property (up && per[5:2] == 4'hF |-> PD_OE[5:2] == {4{drv | EMI_BUS_ACTIVE}})
        else $error("select drive wrong");
    AST_TX_DRIVE: assert property (up && per[6] |-> PD_OE[6] && PD_O[6] == SERIAL_TXD[1])
        else $error("transmit pad wrong");
endmodule : pfc_props
bind pfc_top pfc_props u_props (.SYS_CLK(SYS_CLK), .RESETN(RESETN), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .EMI_REGION_SELECT_N(EMI_REGION_SELECT_N),
    .EMI_BUS_ACTIVE(EMI_BUS_ACTIVE), .SERIAL_TXD(SERIAL_TXD), .PD_O(PD_O), .PD_OE(PD_OE),
    .PD_PU(PD_PU), .TMS_PU(TMS_PU), .TCK_PD(TCK_PD));

// ---- pad_function_and_pullup_control_bench.sv ----
// pad_function_and_pullup_control_bench: directed tests of the pad control block
`timescale 1ns/10ps
module pad_function_and_pullup_control_bench;
    // ======
    // stimulus and dut
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ba = 1'b0;
    logic ack, tms, tdi, tck;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd, got;
    logic [3:0] sel = 4'hF, external_memory_interface = 4'hA;
    // input levels chosen so receive routing differs from the idle default of 1
    logic [1:0] txd = 2'h1, pei = 2'h1, rxd, peo, peoe, pepu;
    logic [7:2] pdi = 6'h15, pdo, pdoe, pdpu;
    int fail_count = 0, n_compared = 0, cycles = 0;
    always #5 clk = ~clk;
    pfc_top u_dut (.SYS_CLK(clk), .RESETN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rd), .WB_ACK_O(ack),
        .EMI_REGION_SELECT_N(external_memory_interface), .EMI_BUS_ACTIVE(ba), .SERIAL_TXD(txd), .SERIAL_RXD(rxd),
        .PD_I(pdi), .PD_O(pdo), .PD_OE(pdoe), .PD_PU(pdpu), .PE_I(pei), .PE_O(peo),
        .PE_OE(peoe), .PE_PU(pepu), .TMS_PU(tms), .TDI_PU(tdi), .TCK_PD(tck));
    // ======
    // shared tasks
    task end_sim;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk); while (ack !== 1'b1);
        got = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0000_0000);
        chk(got, e);
    endtask : rdc
    // ======
    // scenarios
    task t_in_reset;
        chk({pdoe, peoe}, 8'h00);
        chk({pdpu, pepu, tms, tdi, tck}, 11'h7FF);
        chk(rxd, 2'h0);
    endtask : t_in_reset
    task t_defaults;
        chk({pdoe, peoe}, 8'h41);
        chk({peo[0], pdo[6], rxd}, 4'h8);
        rdc(pfc_pkg::ADR_PD_PULL, 32'hFC);
        rdc(pfc_pkg::ADR_PD_PER, 32'hC0);
        rdc(pfc_pkg::ADR_BUS_CTRL, 32'h0);
        rdc(8'h30, 32'h0);
        rdc(pfc_pkg::ADR_PIN_LEVEL, 32'h55);
    endtask : t_defaults
    task t_pulls;
        wb(1'b1, pfc_pkg::ADR_PD_PULL, 32'hF8);
        chk(pdpu, 6'h3E);
        wb(1'b1, pfc_pkg::ADR_PD_PULL, 32'h3C);
        chk(pdpu, 6'h0F);
        wb(1'b1, pfc_pkg::ADR_PE_PULL, 32'h2);
        chk(pepu, 2'h2);
        wb(1'b1, pfc_pkg::ADR_PUD_CTRL, 32'h1);
        chk({tms, tdi, tck}, 3'h1);
    endtask : t_pulls
    task t_gpio;
        wb(1'b1, pfc_pkg::ADR_PD_DIR, 32'h14);
        wb(1'b1, pfc_pkg::ADR_PD_DOUT, 32'h24);
        chk({pdoe[5:2], pdo[5:2]}, 8'h59);
    endtask : t_gpio
    task t_selects;
        wb(1'b1, pfc_pkg::ADR_PD_PER, 32'hFC);
        chk({pdoe[5:2], pdo[5:2]}, 8'h0A);
        ba <= 1'b1;
        @(posedge clk);
        chk(pdoe[5:2], 4'hF);
        ba <= 1'b0;
        external_memory_interface <= 4'h5;
        wb(1'b1, pfc_pkg::ADR_BUS_CTRL, 32'h1);
        chk({pdoe[5:2], pdo[5:2]}, 8'hF5);
    endtask : t_selects
    task t_serial_gpio;
        wb(1'b1, pfc_pkg::ADR_PE_PER, 32'h0);
        wb(1'b1, pfc_pkg::ADR_PE_DIR, 32'h3);
        wb(1'b1, pfc_pkg::ADR_PE_DOUT, 32'h2);
        chk({peoe, peo, rxd}, 6'h39);
    endtask : t_serial_gpio
    task t_reset_again;
        rstn <= 1'b0;
        @(posedge clk);
        chk({pdoe, peoe, pdpu, tms}, 15'h007F);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        rdc(pfc_pkg::ADR_PE_PER, 32'h3);
        chk({pdoe, pepu}, 8'h43);
    endtask : t_reset_again
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        t_in_reset();
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        t_defaults();
        t_pulls();
        t_gpio();
        t_selects();
        t_serial_gpio();
        t_reset_again();
        end_sim();
    end
endmodule : pad_function_and_pullup_control_bench
